/* logic/serial_port_regs.sv */
// serial port control and status registers with simple serial engine
// How it works
// - sync mode: clock source bit set makes us clock master, else slave
// - tx nine-bit select picks nine or eight data bits per character
// - mode bit selects synchronous when set, asynchronous when clear
// - async break request sends break next; hardware clears when done
// - high-speed select picks x16 vs x64 oversampling in async only
// - shift empty status reads 1 when shifter idle; resets to 1
// - tx ninth data supplies the ninth transmitted bit
// - sync mode: any receive enable overrides transmit enable
// - port enable connects pins; clear holds the receive and transmit engines in reset
// - single receive never starts the receiver; in sync master it self-clears when a character is stored
// - continuous receive enables receiver in async mode only; in sync it overrides single
// - nine-bit async with address detect keeps only bit-8-set characters
// - framing flag follows the top unread character
// - overrun flag set on overflow; cleared by clearing continuous receive
// - rx ninth data shows ninth received bit; parity left to software
// - autobaud overflow reads 1 after autobaud timer overflowed
// - receive idle reads 0 from start detect to character end
// - polarity inverts async tx data; selects sync clock edge
// - wide generator select picks 16-bit or 8-bit baud generator
// - wake-up waits for falling edge, sets receive flag, self-clears
// - autobaud enable measures a character; self-clears when done
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "serial_port_map.svh"
module serial_port_regs
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RESET,
   // axi4-lite write address and data
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [7:0]  AWADDR,
   input  wire logic        WVALID,
   output logic             WREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   // axi4-lite write response
   output logic             BVALID,
   input  wire logic        BREADY,
   output logic [1:0]       BRESP,
   // axi4-lite read
   input  wire logic        ARVALID,
   output logic             ARREADY,
   input  wire logic [7:0]  ARADDR,
   output logic             RVALID,
   input  wire logic        RREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   // serial pins
   input  wire logic        RXD_IN,
   output logic             RXD_OUT,
   output logic             RXD_OE,
   input  wire logic        TXC_IN,
   output logic             TXC_OUT,
   output logic             TXC_OE,
   // receive interrupt flag level
   output logic             RX_FLAG
);
   typedef struct packed
   {
      logic [7:0]  txcs;
      logic [7:0]  rxcs_ctl;
      logic [7:0]  bcon;
      logic [15:0] div;
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [7:0]  w_data;
      logic        w_lane;
      logic        bvalid;
      logic        bok;
      logic        rvalid;
      logic [31:0] rdata;
      logic        rok;
      logic [1:0]  sync_rx;
      logic [1:0]  sync_cl;
      logic        rx_prev;
      serial_port_pkg::rx_state_t rst;
      logic [5:0]  sub;
      logic [3:0]  bitn;
      logic [8:0]  shreg;
      logic [8:0]  fifo0;
      logic [8:0]  fifo1;
      logic        fe0;
      logic        fe1;
      logic [1:0]  cnt;
      logic        overrun_error_flag;
      logic        tx_busy;
      logic [11:0] tx_sh;
      logic [3:0]  tx_left;
      logic [5:0]  tx_sub;
      logic        tx_brk;
      logic [15:0] abd_cnt;
      logic        abd_ovf;
      logic        abd_run;
      logic [2:0]  abd_edges;
      logic        wake_flag;
      logic        sclk;
   } state_t;
   state_t s_q;
   state_t s_d;
   logic tick;
   logic div_wr;
   logic rxd;
   logic wr_fire;
   logic rd_fire;
   logic [7:0] rxcs_rd;
   logic [7:0] bc_rd;
   logic [7:0] rd_val;
   logic rd_hit;
   logic [5:0] osr;
   logic fall;
   logic nine_rx;
   logic sync_mode;
   logic pen;

   // --------------------------------------------------------------
   // baud generator
   // --------------------------------------------------------------
   // generator width select
   baud_tick_gen u_baud
   (
      .CLK     (CLK),
      .RESET   (RESET),
      .clear   (div_wr | ~pen),
      .wide    (s_q.bcon[`BC_WIDE_BIT]),
      .divisor (s_q.div),
      .tick    (tick)
   );

   // --------------------------------------------------------------
   // bus handshakes and read mux
   // --------------------------------------------------------------
   assign AWREADY = ~s_q.aw_got & ~s_q.bvalid;
   assign WREADY  = ~s_q.w_got & ~s_q.bvalid;
   assign ARREADY = ~s_q.rvalid;
   assign BVALID  = s_q.bvalid;
   assign BRESP   = s_q.bok ? 2'h0 : 2'h2;
   assign RVALID  = s_q.rvalid;
   assign RDATA   = s_q.rdata;
   assign RRESP   = s_q.rok ? 2'h0 : 2'h2;
   assign RX_FLAG = (s_q.cnt != 2'h0) | s_q.wake_flag;
   assign wr_fire = s_q.aw_got & s_q.w_got;
   assign rd_fire = ARVALID & ~s_q.rvalid;
   assign sync_mode = s_q.txcs[`TX_SYNC_BIT];
   assign pen = s_q.rxcs_ctl[`RX_PEN_BIT];
   assign nine_rx = s_q.rxcs_ctl[`RX_NINE_BIT];
   assign rxd = s_q.sync_rx[1];
   assign fall = s_q.rx_prev & ~rxd;
   assign div_wr = wr_fire & s_q.w_lane
                 & (s_q.aw_addr == `DIVLO_OFFSET || s_q.aw_addr == `DIVHI_OFFSET);
   assign osr = s_q.txcs[`TX_HS_BIT] ? 6'd15 : 6'd63;
   // framing and ninth-bit status from top of fifo
   assign rxcs_rd = {s_q.rxcs_ctl[7:3], s_q.fe0, s_q.overrun_error_flag, s_q.fifo0[8]};
   // baud control read with zeros in unused bits
   assign bc_rd = {s_q.abd_ovf, (s_q.rst == serial_port_pkg::RX_IDLE), 1'b0,
                   s_q.bcon[4:3], 1'b0, s_q.bcon[1:0]};

   // read value decode
   always_comb
   begin
      rd_hit = 1'b1;
      case (ARADDR)
         `TXCS_OFFSET:    rd_val = s_q.txcs;
         `RXCS_OFFSET:    rd_val = rxcs_rd;
         `BAUDCTL_OFFSET: rd_val = bc_rd;
         `RXDATA_OFFSET:  rd_val = s_q.fifo0[7:0];
         `DIVLO_OFFSET:   rd_val = s_q.div[7:0];
         `DIVHI_OFFSET:   rd_val = s_q.div[15:8];
         `TXDATA_OFFSET:  rd_val = 8'h00;
         default:
         begin
            rd_val = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.sync_rx = {s_q.sync_rx[0], RXD_IN};
      s_d.sync_cl = {s_q.sync_cl[0], TXC_IN};
      s_d.rx_prev = rxd;
      // bus capture
      if (AWVALID & AWREADY)
      begin
         s_d.aw_got = 1'b1;
         s_d.aw_addr = AWADDR;
      end
      if (WVALID & WREADY)
      begin
         s_d.w_got = 1'b1;
         s_d.w_data = WDATA[7:0];
         s_d.w_lane = WSTRB[0];
      end
      if (s_q.bvalid & BREADY)
      begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.rvalid & RREADY)
      begin
         s_d.rvalid = 1'b0;
      end
      if (rd_fire)
      begin
         s_d.rvalid = 1'b1;
         s_d.rok = rd_hit;
         s_d.rdata = {24'h000000, rd_val};
         // reading data pops the fifo
         if (ARADDR == `RXDATA_OFFSET && s_q.cnt != 2'h0)
         begin
            s_d.fifo0 = s_q.fifo1;
            s_d.fe0 = s_q.fe1;
            s_d.cnt = s_q.cnt - 2'h1;
         end
      end
      // only writable bits accept software writes
      if (wr_fire)
      begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bok = 1'b1;
         if (s_q.w_lane)
         begin
            case (s_q.aw_addr)
               `TXCS_OFFSET:    s_d.txcs = {s_q.w_data[7:2], s_q.txcs[1], s_q.w_data[0]};
               `RXCS_OFFSET:    s_d.rxcs_ctl = {s_q.w_data[7:3], 3'h0};
               `BAUDCTL_OFFSET: s_d.bcon = s_q.w_data & `BC_WRITE_MASK;
               `DIVLO_OFFSET:   s_d.div[7:0] = s_q.w_data;
               `DIVHI_OFFSET:   s_d.div[15:8] = s_q.w_data;
               `TXDATA_OFFSET:
               begin
                  // receive enables win in sync mode
                  if (s_q.txcs[`TX_EN_BIT] & ~s_q.tx_busy & pen
                      & ~(sync_mode & (s_q.rxcs_ctl[5] | s_q.rxcs_ctl[4])))
                  begin
                     s_d.tx_busy = 1'b1;
                     s_d.tx_brk = s_q.txcs[`TX_BREAK_BIT] & ~sync_mode;
                     // frame carries the ninth data bit only when nine-bit is set, else a stop bit
                     s_d.tx_sh = {2'b11, s_q.txcs[`TX_NINE_BIT] ? s_q.txcs[0] : 1'b1,
                                  s_q.w_data, 1'b0};
                     s_d.tx_left = s_q.txcs[`TX_NINE_BIT] ? 4'd11 : 4'd10;
                     s_d.tx_sub = 6'd0;
                  end
               end
               default: s_d.bok = 1'b0;
            endcase
         end
      end
      if (~s_d.rxcs_ctl[`RX_CONTINUOUS_RECEIVE_ENABLE_BIT])
      begin
         s_d.overrun_error_flag = 1'b0;
      end
      s_d.txcs[`TX_EMPTY_BIT] = ~s_d.tx_busy;
      // transmitter shifting
      if (s_q.tx_busy & tick)
      begin
         s_d.tx_sub = s_q.tx_sub + 6'd1;
         if (s_q.tx_sub >= (sync_mode ? 6'd0 : osr))
         begin
            s_d.tx_sub = 6'd0;
            s_d.tx_sh = {1'b1, s_q.tx_sh[11:1]};
            s_d.tx_left = s_q.tx_left - 4'd1;
            if (s_q.tx_left == 4'd1)
            begin
               s_d.tx_busy = 1'b0;
               if (s_q.tx_brk)
               begin
                  s_d.txcs[`TX_BREAK_BIT] = 1'b0;
               end
               s_d.tx_brk = 1'b0;
               s_d.txcs[`TX_EMPTY_BIT] = 1'b1;
            end
         end
      end
      // sync master toggles its clock on baud ticks
      if (tick & sync_mode & s_q.txcs[`TX_CLOCK_SOURCE_SELECT_BIT])
      begin
         s_d.sclk = ~s_q.sclk;
      end
      // wake-up on falling edge, no character taken
      if (s_q.bcon[`BC_WAKE_BIT] & ~sync_mode)
      begin
         if (fall)
         begin
            s_d.wake_flag = 1'b1;
            s_d.bcon[`BC_WAKE_BIT] = 1'b0;
         end
      end
      else if (s_q.wake_flag & rd_fire)
      begin
         s_d.wake_flag = 1'b0;
      end
      // autobaud counts five falling edges of a sync character
      if (s_q.bcon[`BC_ABD_BIT] & ~sync_mode)
      begin
         if (fall)
         begin
            s_d.abd_edges = s_q.abd_edges + 3'd1;
            s_d.abd_run = 1'b1;
            if (s_q.abd_edges == 3'd4)
            begin
               s_d.div = s_q.abd_cnt >> 4;
               s_d.bcon[`BC_ABD_BIT] = 1'b0;
               s_d.abd_run = 1'b0;
               s_d.abd_edges = 3'd0;
            end
         end
         if (s_q.abd_run)
         begin
            s_d.abd_cnt = s_q.abd_cnt + 16'h0001;
            if (s_q.abd_cnt == 16'hFFFF)
            begin
               s_d.abd_ovf = 1'b1;
            end
         end
      end
      else
      begin
         s_d.abd_cnt = 16'h0000;
         s_d.abd_run = 1'b0;
         s_d.abd_edges = 3'd0;
      end
      // --------------------------------------------------------------
      // receiver
      // --------------------------------------------------------------
      case (s_q.rst)
         serial_port_pkg::RX_IDLE:
         begin
            // enable: continuous receive only, and only in async mode
            if (fall & s_q.rxcs_ctl[`RX_CONTINUOUS_RECEIVE_ENABLE_BIT] & ~s_q.overrun_error_flag & ~sync_mode
                & ~s_q.bcon[`BC_WAKE_BIT] & ~s_q.bcon[`BC_ABD_BIT])
            begin
               s_d.rst = serial_port_pkg::RX_START;
               s_d.sub = 6'd0;
            end
         end
         serial_port_pkg::RX_START:
         begin
            if (tick)
            begin
               s_d.sub = s_q.sub + 6'd1;
               if (s_q.sub == (osr >> 1))
               begin
                  s_d.sub = 6'd0;
                  s_d.bitn = 4'd0;
                  s_d.rst = rxd ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
               end
            end
         end
         serial_port_pkg::RX_DATA:
         begin
            if (tick)
            begin
               s_d.sub = s_q.sub + 6'd1;
               if (s_q.sub == osr)
               begin
                  s_d.sub = 6'd0;
                  s_d.shreg = nine_rx ? {rxd, s_q.shreg[8:1]} : {1'b0, rxd, s_q.shreg[7:1]};
                  s_d.bitn = s_q.bitn + 4'd1;
                  if (s_q.bitn == (nine_rx ? 4'd8 : 4'd7))
                  begin
                     s_d.rst = serial_port_pkg::RX_STOP;
                  end
               end
            end
         end
         serial_port_pkg::RX_STOP:
         begin
            if (tick & (s_q.sub == osr))
            begin
               s_d.rst = serial_port_pkg::RX_IDLE;
               if (~(nine_rx & s_q.rxcs_ctl[`RX_ADDR_BIT] & ~s_q.shreg[8]))
               begin
                  if (s_d.cnt == 2'h2)
                  begin
                     s_d.overrun_error_flag = 1'b1;
                  end
                  else if (s_d.cnt == 2'h0)
                  begin
                     // store frame error and ninth bit
                     s_d.fifo0 = s_q.shreg;
                     s_d.fe0 = ~rxd;
                     s_d.cnt = 2'h1;
                  end
                  else
                  begin
                     s_d.fifo1 = s_q.shreg;
                     s_d.fe1 = ~rxd;
                     s_d.cnt = 2'h2;
                  end
               end
            end
            else if (tick)
            begin
               s_d.sub = s_q.sub + 6'd1;
            end
         end
         default: s_d.rst = serial_port_pkg::RX_IDLE;
      endcase
      // single receive self-clears in sync master
      if (sync_mode & s_q.txcs[`TX_CLOCK_SOURCE_SELECT_BIT] & s_q.rxcs_ctl[`RX_SINGLE_RECEIVE_ENABLE_BIT]
          & ~s_q.rxcs_ctl[`RX_CONTINUOUS_RECEIVE_ENABLE_BIT] & (s_q.cnt != s_d.cnt) & (s_d.cnt != 2'h0))
      begin
         s_d.rxcs_ctl[`RX_SINGLE_RECEIVE_ENABLE_BIT] = 1'b0;
      end
      // port disabled holds engine in reset
      if (~s_d.rxcs_ctl[`RX_PEN_BIT])
      begin
         s_d.rst = serial_port_pkg::RX_IDLE;
         s_d.cnt = 2'h0;
         s_d.fe0 = 1'b0;
         s_d.overrun_error_flag = 1'b0;
         s_d.tx_busy = 1'b0;
         s_d.txcs[`TX_EMPTY_BIT] = 1'b1;
         s_d.wake_flag = 1'b0;
      end
   end

   // --------------------------------------------------------------
   // pin drive
   // --------------------------------------------------------------
   // polarity: async data inversion, sync idle clock level
   assign TXC_OUT = sync_mode ? (s_q.sclk ^ ~s_q.bcon[`BC_POL_BIT])
                  : ((s_q.tx_brk ? 1'b0 : s_q.tx_sh[0]) ^ s_q.bcon[`BC_POL_BIT]);
   // pins owned only when enabled; clock driven as master
   assign TXC_OE  = pen & (~sync_mode | s_q.txcs[`TX_CLOCK_SOURCE_SELECT_BIT]);
   assign RXD_OUT = s_q.tx_sh[0];
   assign RXD_OE  = pen & sync_mode & s_q.tx_busy;

   // state register
   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         s_q <= '0;
         s_q.txcs <= `TXCS_RESET;
         s_q.bcon <= 8'h00;
         s_q.rst <= serial_port_pkg::RX_IDLE;
         s_q.tx_sh <= 12'hFFF;
         s_q.sync_rx <= 2'h3;
         s_q.rx_prev <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end
endmodule // serial_port_regs

/* logic/serial_port_map.svh */
// register offsets, bit positions and reset values of the serial port
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH
`define TXCS_OFFSET      8'h00
`define RXCS_OFFSET      8'h04
`define BAUDCTL_OFFSET   8'h08
`define RXDATA_OFFSET    8'h0C
`define DIVLO_OFFSET     8'h10
`define DIVHI_OFFSET     8'h14
`define TXDATA_OFFSET    8'h18
// transmit control/status bits
`define TX_CLOCK_SOURCE_SELECT_BIT      7
`define TX_NINE_BIT      6
`define TX_EN_BIT        5
`define TX_SYNC_BIT      4
`define TX_BREAK_BIT     3
`define TX_HS_BIT        2
`define TX_EMPTY_BIT     1
`define TX_D9_BIT        0
// receive control/status bits
`define RX_PEN_BIT       7
`define RX_NINE_BIT      6
`define RX_SINGLE_RECEIVE_ENABLE_BIT      5
`define RX_CONTINUOUS_RECEIVE_ENABLE_BIT      4
`define RX_ADDR_BIT      3
`define RX_FRAMING_ERROR_FLAG_BIT      2
`define RX_OVERRUN_ERROR_FLAG_BIT      1
`define RX_D9_BIT        0
// baud control bits
`define BC_OVF_BIT       7
`define BC_IDLE_BIT      6
`define BC_POL_BIT       4
`define BC_WIDE_BIT      3
`define BC_WAKE_BIT      1
`define BC_ABD_BIT       0
`define BC_WRITE_MASK    8'h1B
`define TXCS_RESET       8'h02
`define RXCS_RESET       8'h00
`define BAUDCTL_RESET    8'h40
`endif

/* logic/serial_port_pkg.sv */
// types shared by the serial port register block
package serial_port_pkg;
   typedef enum logic [3:0]
   {
      RX_IDLE  = 4'h1,
      RX_START = 4'h2,
      RX_DATA  = 4'h4,
      RX_STOP  = 4'h8
   } rx_state_t;
endpackage

/* logic/baud_tick_gen.sv */
// baud generator: free running divider with 8- or 16-bit reload
`timescale 1ns/1ps
module baud_tick_gen
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RESET,
   // control
   input  wire logic        clear,
   input  wire logic        wide,
   input  wire logic [15:0] divisor,
   // output
   output logic             tick
);
   typedef struct packed
   {
      logic [15:0] cnt;
   } bstate_t;
   bstate_t s_q;
   bstate_t s_d;
   logic [15:0] limit;

   // next count and one-cycle tick at terminal count
   always_comb
   begin
      limit = wide ? divisor : {8'h00, divisor[7:0]};
      s_d = s_q;
      tick = 1'b0;
      if (clear)
      begin
         s_d.cnt = 16'h0000;
      end
      else if (s_q.cnt >= limit)
      begin
         s_d.cnt = 16'h0000;
         tick = 1'b1;
      end
      else
      begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end
   end

   // state register
   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
endmodule // baud_tick_gen

/* test/serial_peer.sv */
// serial peer model driving asynchronous frames onto the data pin
`timescale 1ns/1ps
module serial_peer
#(
   parameter int BIT_CYCLES = 16
)
(
   // clock
   input  wire logic CLK,
   // line side
   output logic      RXD_IN,
   output logic      TXC_IN
);
   // idle line rests high, as with a pull-up
   initial
   begin
      RXD_IN = 1'b1;
      TXC_IN = 1'b1;
   end

   // ninth bit supplied by sender
   // one frame: start, data lsb first, stop, then one idle bit
   task automatic send_char(input logic [8:0] data, input int nbits, input logic stop);
      logic v;
      for (int b = 0; b < nbits + 3; b++)
      begin
         if (b == 0) v = 1'b0;
         else if (b <= nbits) v = data[b - 1];
         else if (b == nbits + 1) v = stop;
         else v = 1'b1;
         RXD_IN <= v;
         repeat (BIT_CYCLES) @(posedge CLK);
      end
   endtask
endmodule // serial_peer

/* test/serial_port_assertions.sv */
// concurrent checks on the serial port register block ports
`timescale 1ns/1ps
module serial_port_assertions
(
   // clock and reset
   input wire logic        CLK,
   input wire logic        RESET,
   // bus handshakes
   input wire logic        AWVALID, AWREADY, WVALID, WREADY, BVALID,
   input wire logic        ARVALID, ARREADY, RVALID, RREADY,
   // bus payloads
   input wire logic [7:0]  AWADDR,
   input wire logic [7:0]  ARADDR,
   input wire logic [1:0]  BRESP,
   input wire logic [1:0]  RRESP,
   input wire logic [31:0] RDATA,
   // pin enables
   input wire logic        RXD_OE,
   input wire logic        TXC_OE
);
   logic [7:0] aw_q;
   logic [7:0] ar_q;

   // remember the last accepted addresses
   always_ff @(posedge CLK or posedge RESET)
      if (RESET)
      begin
         aw_q <= 8'h00;
         ar_q <= 8'h00;
      end
      else
      begin
         if (AWVALID && AWREADY) aw_q <= AWADDR;
         if (ARVALID && ARREADY) ar_q <= ARADDR;
      end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   // read request steps
   sequence s_ar_taken; ARVALID && ARREADY; endsequence
   sequence s_ar_far; ARVALID && ARREADY && ARADDR > 8'h18; endsequence

   property p_rd_latency; s_ar_taken |=> RVALID; endproperty
   a_rd_latency: assert property (p_rd_latency) else $error("read answer late");
   property p_rd_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
   property p_rd_slverr; s_ar_far |=> RVALID && RRESP == 2'b10 && RDATA == 32'h0; endproperty
   a_rd_slverr: assert property (p_rd_slverr) else $error("unmapped read not refused");
   property p_rd_upper; RVALID |-> RDATA[31:8] == 24'h0; endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
   property p_bc_unused; RVALID && ar_q == 8'h08 |-> RDATA[5] == 1'b0 && RDATA[2] == 1'b0;
   endproperty
   a_bc_unused: assert property (p_bc_unused) else $error("unused bit set");
   property p_wr_latency; AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID; endproperty
   a_wr_latency: assert property (p_wr_latency) else $error("write answer late");
   property p_wr_okay; BVALID && aw_q <= 8'h18 && aw_q[1:0] == 2'b00 |-> BRESP == 2'b00;
   endproperty
   a_wr_okay: assert property (p_wr_okay) else $error("mapped write refused");
   property p_wr_slverr; BVALID && aw_q > 8'h18 |-> BRESP == 2'b10; endproperty
   a_wr_slverr: assert property (p_wr_slverr) else $error("unmapped write accepted");
   property p_pins_idle; $fell(RESET) |-> !RXD_OE && !TXC_OE; endproperty
   a_pins_idle: assert property (p_pins_idle) else $error("pins driven after reset");
endmodule // serial_port_assertions

bind serial_port_regs serial_port_assertions chk
(
   .CLK(CLK), .RESET(RESET), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
   .WREADY(WREADY), .BVALID(BVALID), .ARVALID(ARVALID), .ARREADY(ARREADY),
   .RVALID(RVALID), .RREADY(RREADY), .AWADDR(AWADDR), .ARADDR(ARADDR), .BRESP(BRESP),
   .RRESP(RRESP), .RDATA(RDATA), .RXD_OE(RXD_OE), .TXC_OE(TXC_OE)
);

/* test/tb.sv */
// testbench for the serial port register block
`timescale 1ns/1ps
module tb;
   logic        CLK, RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic        RXD_IN, TXC_IN, RXD_OUT, RXD_OE, TXC_OUT, TXC_OE, RX_FLAG;
   logic [7:0]  AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA, rd;
   logic [3:0]  WSTRB;
   logic [1:0]  BRESP, RRESP, rs;
   logic        hit;
   int          fails, total_checks;

   // clock
   initial CLK = 1'b0;
   always #2 CLK = ~CLK;

   // design and serial peer
   serial_port_regs dut (.CLK(CLK), .RESET(RESET), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
      .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY),
      .RDATA(RDATA), .RRESP(RRESP), .RXD_IN(RXD_IN), .RXD_OUT(RXD_OUT), .RXD_OE(RXD_OE),
      .TXC_IN(TXC_IN), .TXC_OUT(TXC_OUT), .TXC_OE(TXC_OE), .RX_FLAG(RX_FLAG));
   serial_peer #(.BIT_CYCLES(16)) peer (.CLK(CLK), .RXD_IN(RXD_IN), .TXC_IN(TXC_IN));

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic guard(input int n);
      if (n >= 400)
      begin
         fails++;
         tally_and_finish;
      end
   endtask

   // bus write, response ready held high throughout
   task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      int n;
      n = 0;
      AWADDR <= a;
      WDATA <= {24'h0, d};
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      do
      begin
         @(posedge CLK);
         n++;
         if (AWVALID && AWREADY) AWVALID <= 1'b0;
         if (WVALID && WREADY) WVALID <= 1'b0;
      end
      while (!BVALID && n < 400);
      r = BRESP;
      guard(n);
   endtask

   // bus read, read ready held high throughout
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      ARADDR <= a;
      ARVALID <= 1'b1;
      do
      begin
         @(posedge CLK);
         n++;
         if (ARVALID && ARREADY) ARVALID <= 1'b0;
      end
      while (!RVALID && n < 400);
      d = RDATA;
      r = RRESP;
      guard(n);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      axi_write(a, d, rs);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      axi_read(a, rd, rs);
      check_val(rd, exp);
   endtask

   task automatic wait_flag(input int lim, output logic found);
      int n;
      n = 0;
      while (RX_FLAG !== 1'b1 && n < lim)
      begin
         @(posedge CLK);
         n++;
      end
      found = (RX_FLAG === 1'b1);
   endtask

   task automatic t_reset_values;
      rd_chk(8'h00, 32'h02);
      rd_chk(8'h04, 32'h00);
      rd_chk(8'h08, 32'h40);
   endtask

   task automatic t_unmapped;
      axi_read(8'h1C, rd, rs);
      check_val({30'h0, rs}, 32'h2);
      check_val(rd, 32'h0);
      axi_write(8'h1C, 8'hFF, rs);
      check_val({30'h0, rs}, 32'h2);
   endtask

   task automatic t_write_masks;
      wr(8'h04, 8'h8F);
      rd_chk(8'h04, 32'h88);
      wr(8'h08, 8'h3C);
      rd_chk(8'h08, 32'h58);
      wr(8'h08, 8'h00);
      wr(8'h10, 8'hA5);
      rd_chk(8'h10, 32'hA5);
      wr(8'h14, 8'h5A);
      rd_chk(8'h14, 32'h5A);
      wr(8'h10, 8'h00);
      wr(8'h14, 8'h00);
   endtask

   task automatic t_receive;
      wr(8'h00, 8'h04);
      wr(8'h04, 8'h90);
      fork
         peer.send_char(9'h03C, 8, 1'b1);
         begin
            repeat (48) @(posedge CLK);
            rd_chk(8'h08, 32'h00);
         end
      join
      wait_flag(400, hit);
      check_val({31'h0, hit}, 32'h1);
      rd_chk(8'h04, 32'h90);
      rd_chk(8'h0C, 32'h3C);
      peer.send_char(9'h055, 8, 1'b0);
      wait_flag(400, hit);
      rd_chk(8'h04, 32'h94);
      rd_chk(8'h0C, 32'h55);
      repeat (2) @(posedge CLK);
      check_val({31'h0, RX_FLAG}, 32'h0);
   endtask

   task automatic t_overrun;
      repeat (3) peer.send_char(9'h0A1, 8, 1'b1);
      rd_chk(8'h04, 32'h92);
      wr(8'h04, 8'h80);
      rd_chk(8'h04, 32'h80);
      wr(8'h04, 8'h00);
      repeat (2) @(posedge CLK);
      check_val({31'h0, RX_FLAG}, 32'h0);
   endtask

   task automatic t_address;
      wr(8'h04, 8'hD8);
      peer.send_char(9'h011, 9, 1'b1);
      wait_flag(64, hit);
      check_val({31'h0, hit}, 32'h0);
      peer.send_char(9'h1A7, 9, 1'b1);
      wait_flag(400, hit);
      check_val({31'h0, hit}, 32'h1);
      rd_chk(8'h04, 32'hD9);
      rd_chk(8'h0C, 32'hA7);
   endtask

   // nine-bit async frame with ninth bit 0, then inverted idle level
   task automatic t_transmit;
      wr(8'h00, 8'h64);
      rd_chk(8'h00, 32'h66);
      wr(8'h18, 8'h5A);
      rd_chk(8'h00, 32'h64);
      check_val({31'h0, TXC_OUT}, 32'h0);
      repeat (144) @(posedge CLK);
      check_val({31'h0, TXC_OUT}, 32'h0);
      repeat (16) @(posedge CLK);
      check_val({31'h0, TXC_OUT}, 32'h1);
      repeat (24) @(posedge CLK);
      rd_chk(8'h00, 32'h66);
      wr(8'h08, 8'h10);
      check_val({29'h0, RXD_OE, TXC_OE, TXC_OUT}, 32'h2);
   endtask

   // reset, then the scenarios in turn
   initial
   begin
      RESET = 1'b1;
      AWVALID = 1'b0;
      WVALID = 1'b0;
      ARVALID = 1'b0;
      RREADY = 1'b1;
      BREADY = 1'b1;
      AWADDR = 8'h00;
      ARADDR = 8'h00;
      WDATA = 32'h0;
      WSTRB = 4'hF;
      fails = 0;
      total_checks = 0;
      repeat (12) @(posedge CLK);
      RESET <= 1'b0;
      @(posedge CLK);
      t_reset_values();
      t_unmapped();
      t_write_masks();
      t_receive();
      t_overrun();
      t_address();
      t_transmit();
      tally_and_finish();
   end
endmodule // tb
